// File: design/gocr_regs.svh
`ifndef GOCR_REGS_SVH
`define GOCR_REGS_SVH

`define GOCR_PAGE_CH_A 24'h610000
`define GOCR_PAGE_CH_B 24'h610100

`define GOCR_OFS_EST_SEL 8'h34
`define GOCR_OFS_CORR_CTRL 8'h68
`define GOCR_OFS_GAIN 8'ha6

`define GOCR_EST_SEL_MASK 8'h01
`define GOCR_CORR_CTRL_MASK 8'ha7
`define GOCR_GAIN_MASK 8'h0f
`define GOCR_RESET_VALUE 8'h00

`define GOCR_BIT_EXT_EST 0
`define GOCR_BIT_HOLD_HI 7
`define GOCR_BIT_HOLD_MID 5
`define GOCR_BIT_CORR_DIS 2
`define GOCR_BIT_HOLD_LO 1

`define GOCR_HOLD_RUN 3'h3
`define GOCR_HOLD_FREEZE 3'h7
`define GOCR_GAIN_CODE_MAX 4'hb

`define GOCR_GAIN_FRAC_BITS 14
`define GOCR_SAMPLE_MAX 14'sh1fff
`define GOCR_SAMPLE_MIN 14'sh2000

`endif

// File: design/gocr_pkg.sv
package gocr_pkg;

  typedef logic signed [13:0] gocr_sample_type;

  typedef struct packed {
    logic external_estimate_select;
    logic corrector_disable;
    logic [2:0] hold_setting;
  } gocr_corr_ctrl_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [23:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gocr_reg_req_type;

endpackage : gocr_pkg

// File: design/gocr_gain_sat.sv
`timescale 1ns/10ps
`include "gocr_regs.svh"

module gocr_gain_sat (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic [3:0] i_output_gain_code,
  input wire logic i_valid,
  input wire gocr_pkg::gocr_sample_type i_sample,
  output logic o_valid,
  output gocr_pkg::gocr_sample_type o_sample
);

  // Linear gain in Q2.14 for 0..11 dB; unused codes fall back to unity
  function automatic logic [16:0] gain_lut(input logic [3:0] code);
    case (code)
      4'h0: gain_lut = 17'h04000;
      4'h1: gain_lut = 17'h047cf;
      4'h2: gain_lut = 17'h05092;
      4'h3: gain_lut = 17'h05a67;
      4'h4: gain_lut = 17'h0656f;
      4'h5: gain_lut = 17'h071cf;
      4'h6: gain_lut = 17'h07fb2;
      4'h7: gain_lut = 17'h08f47;
      4'h8: gain_lut = 17'h0a0c3;
      4'h9: gain_lut = 17'h0b460;
      4'ha: gain_lut = 17'h0ca63;
      4'hb: gain_lut = 17'h0e316;
      default: gain_lut = 17'h04000;
    endcase
  endfunction : gain_lut

  wire logic signed [17:0] gain_s = $signed({1'b0, gain_lut(i_output_gain_code)});
  wire logic signed [31:0] product = i_sample * gain_s;
  wire logic signed [17:0] scaled = product[31:14];
  wire logic too_high = scaled > 18'sh01fff;
  wire logic too_low = scaled < -18'sh02000;
  // Clip rather than wrap: a wrapped peak becomes a full-scale glitch
  wire gocr_pkg::gocr_sample_type clipped = too_high ? `GOCR_SAMPLE_MAX :
                                            too_low ? `GOCR_SAMPLE_MIN :
                                            scaled[13:0];

  logic valid_r;
  gocr_pkg::gocr_sample_type sample_r;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      valid_r <= 1'b0;
      sample_r <= '0;
    end
    else
    begin
      valid_r <= i_valid;
      if (i_valid)
        sample_r <= clipped;
    end
  end

  assign o_valid = valid_r;
  assign o_sample = sample_r;

  property p_unity_gain;
    @(posedge i_clk_sys) disable iff (i_reset)
      (i_valid && i_output_gain_code == 4'h0) |=> (o_sample == $past(i_sample));
  endproperty
  a_unity_gain: assert property (p_unity_gain) else $error("0 dB code altered sample");

  property p_clip_top;
    @(posedge i_clk_sys) disable iff (i_reset)
      (i_valid && i_output_gain_code == 4'hb && i_sample > 14'sh0a00)
        |=> (o_sample == 14'sh1fff);
  endproperty
  a_clip_top: assert property (p_clip_top) else $error("overflow did not saturate high");

  property p_clip_bottom;
    @(posedge i_clk_sys) disable iff (i_reset)
      (i_valid && i_output_gain_code == 4'hb && i_sample < -14'sh0a00)
        |=> (o_sample == -14'sh2000);
  endproperty
  a_clip_bottom: assert property (p_clip_bottom) else $error("overflow did not saturate low");

endmodule : gocr_gain_sat

// File: design/gocr_top.sv
`timescale 1ns/10ps
`include "gocr_regs.svh"

// Overview of operation
// - The low nibble of the gain register sets 0 dB at 0000 up to 11 dB at 1011 in 1 dB steps.
// - Bit 0 of the estimate-select register makes the corrector use the external estimate.
// - Bits 7, 5 and 1 of the correction control register together form a 3-bit hold setting.
// - Hold setting 111 freezes estimation and keeps the last computed offset applied.
// - With the disable bit at 0 and hold setting 011 the corrector runs and removes the fs/8, fs/4, 3fs/8, fs/2 spurs.
// - With the disable bit at 1 the corrector is bypassed and corrects nothing.
// - Channel B has its own control register at offset_corr_control_a laid out like channel A's.
// - Registers are reached through page 610000h for channel A and 610100h for channel B.

module gocr_top (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire gocr_pkg::gocr_reg_req_type i_reg_req,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire logic [1:0] i_sample_valid,
  input wire gocr_pkg::gocr_sample_type i_sample_a,
  input wire gocr_pkg::gocr_sample_type i_sample_b,
  output logic [1:0] o_sample_valid,
  output gocr_pkg::gocr_sample_type o_sample_a,
  output gocr_pkg::gocr_sample_type o_sample_b,
  output gocr_pkg::gocr_corr_ctrl_type o_corr_ctrl_a,
  output gocr_pkg::gocr_corr_ctrl_type o_corr_ctrl_b,
  output logic [1:0] o_corr_estimating,
  output logic [1:0] o_corr_frozen,
  output logic [1:0] o_corr_bypass
);

  function automatic logic page_hit(input logic [23:0] page, input logic ch);
    page_hit = (page == (ch ? `GOCR_PAGE_CH_B : `GOCR_PAGE_CH_A));
  endfunction : page_hit

  logic [7:0] est_r [2];
  logic [7:0] ctrl_r [2];
  logic [7:0] gain_r [2];
  logic [7:0] rdata_r;
  logic rvalid_r;

  wire logic [1:0] ch_hit;
  wire logic [7:0] ch_rdata [2];
  wire gocr_pkg::gocr_corr_ctrl_type corr_ctrl [2];
  wire gocr_pkg::gocr_sample_type samp_in [2];
  wire gocr_pkg::gocr_sample_type samp_out [2];

  assign samp_in[0] = i_sample_a;
  assign samp_in[1] = i_sample_b;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : g_chan
      wire logic wr_hit = i_reg_req.wr && ch_hit[ch];
      wire logic wr_est = wr_hit && i_reg_req.addr == `GOCR_OFS_EST_SEL;
      wire logic wr_ctrl = wr_hit && i_reg_req.addr == `GOCR_OFS_CORR_CTRL;
      wire logic wr_gain = wr_hit && i_reg_req.addr == `GOCR_OFS_GAIN;

      assign ch_hit[ch] = page_hit(i_reg_req.page, ch == 1);
      // Write-only zero bits are dropped so they always read back as zero
      assign ch_rdata[ch] =
        (i_reg_req.addr == `GOCR_OFS_EST_SEL) ? est_r[ch] :
        (i_reg_req.addr == `GOCR_OFS_CORR_CTRL) ? ctrl_r[ch] :
        (i_reg_req.addr == `GOCR_OFS_GAIN) ? gain_r[ch] : 8'h00;

      always_ff @(posedge i_clk_sys)
      begin
        if (i_reset)
        begin
          est_r[ch] <= `GOCR_RESET_VALUE;
          ctrl_r[ch] <= `GOCR_RESET_VALUE;
          gain_r[ch] <= `GOCR_RESET_VALUE;
        end
        else
        begin
          if (wr_est)
            est_r[ch] <= i_reg_req.wdata & `GOCR_EST_SEL_MASK;
          if (wr_ctrl)
            ctrl_r[ch] <= i_reg_req.wdata & `GOCR_CORR_CTRL_MASK;
          if (wr_gain)
            gain_r[ch] <= i_reg_req.wdata & `GOCR_GAIN_MASK;
        end
      end

      assign corr_ctrl[ch].external_estimate_select = est_r[ch][`GOCR_BIT_EXT_EST];
      assign corr_ctrl[ch].corrector_disable = ctrl_r[ch][`GOCR_BIT_CORR_DIS];
      assign corr_ctrl[ch].hold_setting = {ctrl_r[ch][`GOCR_BIT_HOLD_HI],
                                           ctrl_r[ch][`GOCR_BIT_HOLD_MID],
                                           ctrl_r[ch][`GOCR_BIT_HOLD_LO]};
      // Disable overrides hold; undefined hold codes leave the corrector idle
      assign o_corr_bypass[ch] = corr_ctrl[ch].corrector_disable;
      assign o_corr_estimating[ch] = !corr_ctrl[ch].corrector_disable &&
        corr_ctrl[ch].hold_setting == `GOCR_HOLD_RUN;
      assign o_corr_frozen[ch] = !corr_ctrl[ch].corrector_disable &&
        corr_ctrl[ch].hold_setting == `GOCR_HOLD_FREEZE;

      gocr_gain_sat u_gain (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_output_gain_code(gain_r[ch][3:0]),
        .i_valid(i_sample_valid[ch]),
        .i_sample(samp_in[ch]),
        .o_valid(o_sample_valid[ch]),
        .o_sample(samp_out[ch])
      );
    end
  endgenerate

  // Unmapped page or offset reads back zero, still with a valid strobe
  wire logic [7:0] rd_mux = ch_hit[0] ? ch_rdata[0] : ch_hit[1] ? ch_rdata[1] : 8'h00;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rvalid_r <= i_reg_req.rd;
      if (i_reg_req.rd)
        rdata_r <= rd_mux;
    end
  end

  assign o_reg_rdata = rdata_r;
  assign o_reg_rvalid = rvalid_r;
  assign o_corr_ctrl_a = corr_ctrl[0];
  assign o_corr_ctrl_b = corr_ctrl[1];
  assign o_sample_a = samp_out[0];
  assign o_sample_b = samp_out[1];

  // Shapes of bus requests that the checks below key on
  sequence s_wr_at(logic [23:0] pg, logic [7:0] ad);
    i_reg_req.wr && i_reg_req.page == pg && i_reg_req.addr == ad;
  endsequence

  sequence s_wr_ctrl_a(logic [7:0] d);
    s_wr_at(`GOCR_PAGE_CH_A, `GOCR_OFS_CORR_CTRL) ##0 i_reg_req.wdata == d;
  endsequence

  sequence s_rd_gain_a;
    i_reg_req.rd && !i_reg_req.wr && i_reg_req.page == `GOCR_PAGE_CH_A &&
    i_reg_req.addr == `GOCR_OFS_GAIN;
  endsequence

  // All-ones write, one idle cycle, then read back: reserved bits must vanish
  property p_gain_readback;
    @(posedge i_clk_sys) disable iff (i_reset)
      s_wr_at(`GOCR_PAGE_CH_A, `GOCR_OFS_GAIN) ##0 i_reg_req.wdata == 8'hff ##2 s_rd_gain_a
        |=> (o_reg_rvalid && o_reg_rdata == `GOCR_GAIN_MASK);
  endproperty
  a_gain_readback: assert property (p_gain_readback) else $error("gain code lost");

  property p_ext_est;
    @(posedge i_clk_sys) disable iff (i_reset)
      s_wr_at(`GOCR_PAGE_CH_A, `GOCR_OFS_EST_SEL)
        |=> (o_corr_ctrl_a.external_estimate_select ==
             $past(i_reg_req.wdata[`GOCR_BIT_EXT_EST]));
  endproperty
  a_ext_est: assert property (p_ext_est) else $error("external estimate select wrong");

  property p_ext_est_b;
    @(posedge i_clk_sys) disable iff (i_reset)
      s_wr_at(`GOCR_PAGE_CH_B, `GOCR_OFS_EST_SEL)
        |=> (o_corr_ctrl_b.external_estimate_select ==
             $past(i_reg_req.wdata[`GOCR_BIT_EXT_EST]));
  endproperty
  a_ext_est_b: assert property (p_ext_est_b) else $error("B estimate select wrong");

  property p_hold_bits;
    @(posedge i_clk_sys) disable iff (i_reset)
      s_wr_at(`GOCR_PAGE_CH_B, `GOCR_OFS_CORR_CTRL)
        |=> (o_corr_ctrl_b.hold_setting == {$past(i_reg_req.wdata[`GOCR_BIT_HOLD_HI]),
                                            $past(i_reg_req.wdata[`GOCR_BIT_HOLD_MID]),
                                            $past(i_reg_req.wdata[`GOCR_BIT_HOLD_LO])});
  endproperty
  a_hold_bits: assert property (p_hold_bits) else $error("hold setting mis-formed");

  property p_hold_bits_a;
    @(posedge i_clk_sys) disable iff (i_reset)
      s_wr_at(`GOCR_PAGE_CH_A, `GOCR_OFS_CORR_CTRL)
        |=> (o_corr_ctrl_a.hold_setting == {$past(i_reg_req.wdata[`GOCR_BIT_HOLD_HI]),
                                            $past(i_reg_req.wdata[`GOCR_BIT_HOLD_MID]),
                                            $past(i_reg_req.wdata[`GOCR_BIT_HOLD_LO])});
  endproperty
  a_hold_bits_a: assert property (p_hold_bits_a) else $error("A hold setting mis-formed");

  property p_freeze;
    @(posedge i_clk_sys) disable iff (i_reset)
      s_wr_ctrl_a(8'ha2) |=> (o_corr_frozen[0] && !o_corr_estimating[0]);
  endproperty
  a_freeze: assert property (p_freeze) else $error("111 did not freeze");

  property p_run;
    @(posedge i_clk_sys) disable iff (i_reset)
      s_wr_ctrl_a(8'h22) |=> (o_corr_estimating[0] && !o_corr_bypass[0]);
  endproperty
  a_run: assert property (p_run) else $error("011 with enable did not run");

  property p_bypass;
    @(posedge i_clk_sys) disable iff (i_reset)
      s_wr_ctrl_a(8'h26) |=> (o_corr_bypass[0] && !o_corr_estimating[0] && !o_corr_frozen[0]);
  endproperty
  a_bypass: assert property (p_bypass) else $error("disable did not bypass");

  property p_chan_separate;
    @(posedge i_clk_sys) disable iff (i_reset)
      (i_reg_req.wr && i_reg_req.page == `GOCR_PAGE_CH_B) |=> $stable(o_corr_ctrl_a);
  endproperty
  a_chan_separate: assert property (p_chan_separate) else $error("B write hit A");

  property p_chan_separate_b;
    @(posedge i_clk_sys) disable iff (i_reset)
      (i_reg_req.wr && i_reg_req.page == `GOCR_PAGE_CH_A) |=> $stable(o_corr_ctrl_b);
  endproperty
  a_chan_separate_b: assert property (p_chan_separate_b) else $error("A write hit B");

  property p_page_decode;
    @(posedge i_clk_sys) disable iff (i_reset)
      (i_reg_req.wr && i_reg_req.page != `GOCR_PAGE_CH_A && i_reg_req.page != `GOCR_PAGE_CH_B)
        |=> ($stable(o_corr_ctrl_a) && $stable(o_corr_ctrl_b));
  endproperty
  a_page_decode: assert property (p_page_decode) else $error("foreign page changed regs");

  // Both channel pages must answer every read one cycle later
  property p_rd_strobe;
    @(posedge i_clk_sys) disable iff (i_reset)
      (i_reg_req.rd &&
       (i_reg_req.page == `GOCR_PAGE_CH_A || i_reg_req.page == `GOCR_PAGE_CH_B))
        |=> o_reg_rvalid;
  endproperty
  a_rd_strobe: assert property (p_rd_strobe) else $error("page read not answered");

endmodule : gocr_top

// File: tb/tb_top.sv
`timescale 1ns/10ps
`include "gocr_regs.svh"

module tb_top;
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  gocr_pkg::gocr_reg_req_type req = '0;
  logic [1:0] smp_valid = 2'h0;
  gocr_pkg::gocr_sample_type smp_a = '0;
  gocr_pkg::gocr_sample_type smp_b = '0;
  logic [7:0] o_reg_rdata;
  logic o_reg_rvalid;
  logic [1:0] o_sample_valid;
  gocr_pkg::gocr_sample_type o_sample_a;
  gocr_pkg::gocr_sample_type o_sample_b;
  gocr_pkg::gocr_corr_ctrl_type o_corr_ctrl_a;
  gocr_pkg::gocr_corr_ctrl_type o_corr_ctrl_b;
  logic [1:0] o_corr_estimating;
  logic [1:0] o_corr_frozen;
  logic [1:0] o_corr_bypass;
  int errors = 0;
  int total_checks = 0;
  logic [23:0] pages [2] = '{`GOCR_PAGE_CH_A, `GOCR_PAGE_CH_B};
  logic [7:0] offs [3] = '{`GOCR_OFS_EST_SEL, `GOCR_OFS_CORR_CTRL, `GOCR_OFS_GAIN};
  logic [7:0] masks [3] = '{`GOCR_EST_SEL_MASK, `GOCR_CORR_CTRL_MASK, `GOCR_GAIN_MASK};
  wire logic [15:0] ctl = {o_corr_ctrl_a, o_corr_ctrl_b, o_corr_estimating, o_corr_frozen,
                           o_corr_bypass};

  always #4 i_clk_sys = ~i_clk_sys;

  gocr_top uut (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_reg_req(req),
    .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid),
    .i_sample_valid(smp_valid),
    .i_sample_a(smp_a),
    .i_sample_b(smp_b),
    .o_sample_valid(o_sample_valid),
    .o_sample_a(o_sample_a),
    .o_sample_b(o_sample_b),
    .o_corr_ctrl_a(o_corr_ctrl_a),
    .o_corr_ctrl_b(o_corr_ctrl_b),
    .o_corr_estimating(o_corr_estimating),
    .o_corr_frozen(o_corr_frozen),
    .o_corr_bypass(o_corr_bypass)
  );

  task give_verdict;
    $display("Checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  task fail(input string msg);
    errors++;
    $display("Error at %0t: %s", $time, msg);
  endtask : fail

  task chk_reg(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
      fail($sformatf("register byte %h, expected %h", got, exp));
  endtask : chk_reg

  task chk_ctl(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
      fail($sformatf("control outputs %h, expected %h", got, exp));
  endtask : chk_ctl

  // Tolerance covers rounding of the gain table, which is the designer's choice
  task chk_smp(input gocr_pkg::gocr_sample_type got, input int exp, input int tol);
    int d;
    total_checks++;
    d = int'(got) - exp;
    if ((^got) === 1'bx || d > tol || d < -tol)
      fail($sformatf("sample %0d, expected %0d", got, exp));
  endtask : chk_smp

  task wr(input logic [23:0] pg, input logic [7:0] ad, input logic [7:0] wd);
    @(posedge i_clk_sys);
    req <= '{wr: 1'b1, rd: 1'b0, page: pg, addr: ad, wdata: wd};
    @(posedge i_clk_sys);
    req.wr <= 1'b0;
    #1;
  endtask : wr

  // Answer comes exactly one cycle after the read strobe
  task rd_chk(input logic [23:0] pg, input logic [7:0] ad, input logic [7:0] exp);
    @(posedge i_clk_sys);
    req <= '{wr: 1'b0, rd: 1'b1, page: pg, addr: ad, wdata: 8'h00};
    @(posedge i_clk_sys);
    req.rd <= 1'b0;
    #1;
    chk_reg({7'h00, o_reg_rvalid}, 8'h01);
    chk_reg(o_reg_rdata, exp);
  endtask : rd_chk

  task smp(input int a, input int b);
    @(posedge i_clk_sys);
    smp_valid <= 2'h3;
    smp_a <= a[13:0];
    smp_b <= b[13:0];
    @(posedge i_clk_sys);
    smp_valid <= 2'h0;
    #1;
    chk_reg({6'h00, o_sample_valid}, 8'h03);
  endtask : smp

  initial
  begin
    repeat (5000) @(posedge i_clk_sys);
    fail("run did not finish in time");
    give_verdict();
  end

  initial
  begin
    repeat (16) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    #1;
    chk_ctl(ctl, 16'h0000);
    for (int p = 0; p < 2; p++)
      for (int k = 0; k < 3; k++)
        rd_chk(pages[p], offs[k], `GOCR_RESET_VALUE);
    for (int p = 0; p < 2; p++)
      for (int k = 0; k < 3; k++)
      begin
        wr(pages[p], offs[k], 8'hff);
        rd_chk(pages[p], offs[k], masks[k]);
      end
    chk_ctl(ctl, {5'h1f, 5'h1f, 2'h0, 2'h0, 2'h3});
    rd_chk(pages[0], 8'h35, 8'h00);
    wr(24'h610200, `GOCR_OFS_CORR_CTRL, 8'h00);
    chk_ctl(ctl, {5'h1f, 5'h1f, 2'h0, 2'h0, 2'h3});
    wr(pages[0], `GOCR_OFS_CORR_CTRL, 8'h22);
    wr(pages[1], `GOCR_OFS_CORR_CTRL, 8'ha2);
    wr(pages[0], `GOCR_OFS_EST_SEL, 8'h00);
    chk_ctl(ctl, {5'h03, 5'h17, 2'h1, 2'h2, 2'h0});
    wr(pages[0], `GOCR_OFS_CORR_CTRL, 8'h26);
    chk_ctl(ctl, {5'h0b, 5'h17, 2'h0, 2'h2, 2'h1});
    wr(pages[0], `GOCR_OFS_CORR_CTRL, 8'ha2);
    chk_ctl(ctl, {5'h07, 5'h17, 2'h0, 2'h3, 2'h0});
    // Channel B still holds code 1111, which reads as 0 dB
    for (int g = 0; g < 12; g++)
    begin
      wr(pages[0], `GOCR_OFS_GAIN, g[7:0]);
      smp(1000, 1000);
      chk_smp(o_sample_a, int'(1000.0 * 10.0 ** (g / 20.0)), 2);
      chk_smp(o_sample_b, 1000, 0);
    end
    wr(pages[1], `GOCR_OFS_GAIN, 8'h0b);
    smp(8191, -8192);
    chk_smp(o_sample_a, 8191, 0);
    chk_smp(o_sample_b, -8192, 0);
    smp(100, -100);
    chk_smp(o_sample_a, 354, 1);
    chk_smp(o_sample_b, -355, 1);
    smp(3000, -3000);
    chk_smp(o_sample_a, 8191, 0);
    chk_smp(o_sample_b, -8192, 0);
    // Mid-run reset must bring every register and output back to idle
    @(posedge i_clk_sys);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    #1;
    chk_ctl(ctl, 16'h0000);
    chk_smp(o_sample_a, 0, 0);
    rd_chk(pages[1], `GOCR_OFS_GAIN, `GOCR_RESET_VALUE);
    smp(100, -100);
    chk_smp(o_sample_a, 100, 0);
    chk_smp(o_sample_b, -100, 0);
    give_verdict();
  end
endmodule : tb_top
